// ### common/tioc_pkg.sv
// constants shared by the timer i/o control and interrupt enable block
`default_nettype none
package tioc_pkg;
	// ==========================================================
	// register byte addresses on the apb slave
	localparam logic [7:0] OFS_IOCTL2 = 8'h00;
	localparam logic [7:0] OFS_IER0   = 8'h04;
	localparam logic [7:0] OFS_IER1   = 8'h08;
	localparam logic [7:0] OFS_IER2   = 8'h0C;
	localparam logic [7:0] OFS_STAT0  = 8'h10;
	localparam logic [7:0] OFS_STAT1  = 8'h14;
	localparam logic [7:0] OFS_STAT2  = 8'h18;
	localparam logic [7:0] OFS_GRA2   = 8'h1C;
	localparam logic [7:0] OFS_GRB2   = 8'h20;
	// ==========================================================
	// reset values and writable masks
	localparam logic [7:0] IOCTL_RST  = 8'h00;
	localparam logic [7:0] IER_RST    = 8'h40;
	localparam logic [7:0] IER_MASK0  = 8'h9F;
	localparam logic [7:0] IER_MASK12 = 8'hB3;
	localparam logic [7:0] STAT_MASK0 = 8'h1F;
	localparam logic [7:0] STAT_MASK12 = 8'h33;
	localparam logic [7:0] STAT_FIXED = 8'hC0;
	// ==========================================================
	// enable and flag bit positions
	localparam int BIT_ADC   = 7;
	localparam int BIT_ONE   = 6;
	localparam int BIT_UDF   = 5;
	localparam int BIT_OVF   = 4;
	localparam int BIT_MD    = 3;
	localparam int BIT_MC    = 2;
	localparam int BIT_MB    = 1;
	localparam int BIT_MA    = 0;
	localparam int FLD_B_LSB = 4;
	localparam int FLD_A_LSB = 0;
	// ==========================================================
	// function select field layout
	localparam int FS_CAPT  = 3;
	localparam int FS_INIT  = 2;
	localparam logic [1:0] OC_OFF    = 2'h0;
	localparam logic [1:0] OC_DRV0   = 2'h1;
	localparam logic [1:0] OC_DRV1   = 2'h2;
	localparam logic [1:0] OC_TOGGLE = 2'h3;
	localparam logic [1:0] IC_RISE   = 2'h0;
	localparam logic [1:0] IC_FALL   = 2'h1;
endpackage : tioc_pkg
`default_nettype wire

// ### rtl/tioc_top.sv
// capture/compare pin control, interrupt enables and status flags of a 3-channel timer
// ==========================================================
// What this block does
// RQ1 - ch2 control holds B field high, A low
// RQ2 - codes 0000 and 0100: compare, pin disabled
// RQ3 - codes 0001..0011: init 0, drive0/drive1/toggle
// RQ4 - codes 0101..0111: init 1, drive0/drive1/toggle
// RQ5 - top bit set: capture on rise/fall/both
// RQ6 - three enable registers reset to 0x40
// RQ7 - bit 7 lets match A start conversion
// RQ8 - enable bit 6 reads one always
// RQ9 - bit 5 enables underflow request, ch1/2
// RQ10 - ch0 enable bit 5 reads zero
// RQ11 - bit 4 enables overflow request, all
// RQ12 - ch0 bit 3 enables match D request
// RQ13 - ch0 bit 2 enables match C request
// RQ14 - ch1/2 enable bits 3,2 read-only
// RQ15 - bit 1 enables match B request
// RQ16 - bit 0 enables match A request
// RQ17 - overflow on up-wrap, underflow on down-wrap
// RQ18 - match flag on compare equal or capture
// RQ19 - flag clears by zero write after read
// RQ20 - request is flag AND enable, held
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tioc_top
	import tioc_pkg::*;
#(
	parameter int CNT_W = 16
) (
	// clock and reset
	input  wire logic             REF_CLK,
	input  wire logic             RST_B,
	input  wire logic             STANDBY,
	// apb slave
	input  wire logic             PSEL,
	input  wire logic             PENABLE,
	input  wire logic             PWRITE,
	input  wire logic [7:0]       PADDR,
	input  wire logic [31:0]      PWDATA,
	output logic      [31:0]      PRDATA,
	output logic                  PREADY,
	output logic                  PSLVERR,
	// channel counters and outside match events
	input  wire logic [CNT_W-1:0] CH0_COUNT,
	input  wire logic [CNT_W-1:0] CH1_COUNT,
	input  wire logic [CNT_W-1:0] CH2_COUNT,
	input  wire logic [3:0]       CH0_MATCH,
	input  wire logic [1:0]       CH1_MATCH,
	// channel 2 pins
	input  wire logic             CH2_PIN_A_IN,
	output logic                  CH2_PIN_A_OUT,
	output logic                  CH2_PIN_A_OE,
	input  wire logic             CH2_PIN_B_IN,
	output logic                  CH2_PIN_B_OUT,
	output logic                  CH2_PIN_B_OE,
	// requests to interrupt controller and converter
	output logic      [2:0]       OVERFLOW_IRQ,
	output logic      [2:0]       UNDERFLOW_IRQ,
	output logic      [2:0]       MATCH_A_IRQ,
	output logic      [2:0]       MATCH_B_IRQ,
	output logic                  MATCH_C_IRQ,
	output logic                  MATCH_D_IRQ,
	output logic      [2:0]       ADC_START_REQ
);
	if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
		$error("CNT_W must lie in 2..32");
	end

	// ==========================================================
	// apb decode; answer comes one cycle into the access phase
	logic             ready_q;
	logic [31:0]      rdata_q;
	logic             slverr_q;
	logic [7:0]       ioctl_q;
	logic [7:0]       ier_q  [3];
	logic [7:0]       stat_q [3];
	logic [7:0]       arm_q  [3];
	logic [CNT_W-1:0] gr_q   [2];
	logic [CNT_W-1:0] cnt_prev_q [3];
	logic [CNT_W-1:0] cnt    [3];
	logic [7:0]       ev     [3];
	logic [7:0]       stat_d [3];

	wire acc      = PSEL & PENABLE;
	wire wr_done  = acc & ready_q & PWRITE;
	wire rd_done  = acc & ready_q & ~PWRITE;
	wire hit_io   = (PADDR == OFS_IOCTL2);
	wire hit_ga   = (PADDR == OFS_GRA2);
	wire hit_gb   = (PADDR == OFS_GRB2);
	wire [2:0] hit_ier  = {PADDR == OFS_IER2, PADDR == OFS_IER1, PADDR == OFS_IER0};
	wire [2:0] hit_stat = {PADDR == OFS_STAT2, PADDR == OFS_STAT1, PADDR == OFS_STAT0};
	wire mapped   = hit_io | hit_ga | hit_gb | (|hit_ier) | (|hit_stat);
	wire [7:0] wb = PWDATA[7:0];

	assign cnt[0] = CH0_COUNT;
	assign cnt[1] = CH1_COUNT;
	assign cnt[2] = CH2_COUNT;

	// read mux, zero for unmapped and upper bits
	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0000_0000;
		if (hit_io)
			rmux[7:0] = ioctl_q;
		if (hit_ga)
			rmux[CNT_W-1:0] = gr_q[0];
		if (hit_gb)
			rmux[CNT_W-1:0] = gr_q[1];
		for (int c = 0; c < 3; c++) begin
			if (hit_ier[c])
				rmux[7:0] = ier_q[c];
			if (hit_stat[c])
				rmux[7:0] = stat_q[c] | STAT_FIXED;
		end
	end

	// bus answer flops; two-cycle access keeps prdata registered
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ready_q  <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			slverr_q <= 1'b0;
		end else begin
			ready_q  <= acc & ~ready_q;
			rdata_q  <= (acc & ~ready_q) ? rmux : rdata_q;
			slverr_q <= acc & ~ready_q & ~mapped;
		end
	end
	assign PREADY  = ready_q;
	assign PRDATA  = rdata_q;
	assign PSLVERR = slverr_q;

	// ==========================================================
	// channel 2 i/o control register
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B)
			ioctl_q <= IOCTL_RST;
		else if (STANDBY)
			ioctl_q <= IOCTL_RST;
		else if (wr_done & hit_io)
			ioctl_q <= wb;                          // [RQ1]
	end

	// ==========================================================
	// interrupt enable registers; fixed bits forced on every write
	localparam logic [7:0] IER_WMASK [3] = '{IER_MASK0, IER_MASK12, IER_MASK12};
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int c = 0; c < 3; c++)
				ier_q[c] <= IER_RST;                // [RQ6]
		end else begin
			for (int c = 0; c < 3; c++) begin
				if (STANDBY)
					ier_q[c] <= IER_RST;            // [RQ6]
				else if (wr_done & hit_ier[c])
					ier_q[c] <= (wb & IER_WMASK[c]) | IER_RST; // [RQ8] [RQ10] [RQ14]
			end
		end
	end

	// ==========================================================
	// channel 2 capture/compare: one slice per general register
	logic [1:0] match2;
	logic [1:0] pin_q;
	logic [1:0] oe_q;
	logic [1:0] eq_q;
	logic [1:0] pin_prev_q;
	wire  [1:0] pin_in = {CH2_PIN_B_IN, CH2_PIN_A_IN};
	wire  [1:0] gr_hit = {hit_gb, hit_ga};

	for (genvar g = 0; g < 2; g++) begin : g_slice
		wire [3:0] fsel = ioctl_q[4*g+3 -: 4];   // [RQ1]
		wire [3:0] fnew = wb[4*g+3 -: 4];
		wire capt  = fsel[FS_CAPT];
		wire eq    = (CH2_COUNT == gr_q[g]);
		wire cmp   = ~capt & eq & ~eq_q[g];       // [RQ18]
		wire rise  = pin_in[g] & ~pin_prev_q[g];
		wire fall  = ~pin_in[g] & pin_prev_q[g];
		wire edge_ok = fsel[1] ? (rise | fall) :
			(fsel[1:0] == IC_FALL) ? fall : rise; // [RQ5]
		wire capt_ev = capt & edge_ok;
		wire io_wr   = wr_done & hit_io;
		assign match2[g] = cmp | capt_ev;         // [RQ18]

		// general register: capture beats a software write
		always_ff @(posedge REF_CLK or negedge RST_B) begin
			if (!RST_B)
				gr_q[g] <= '1;
			else if (capt_ev)
				gr_q[g] <= CH2_COUNT;               // [RQ5]
			else if (wr_done & gr_hit[g])
				gr_q[g] <= PWDATA[CNT_W-1:0];
		end

		// pin driver: initial level on set-up, action on each match
		always_ff @(posedge REF_CLK or negedge RST_B) begin
			if (!RST_B) begin
				pin_q[g]      <= 1'b0;
				oe_q[g]       <= 1'b0;
				eq_q[g]       <= 1'b0;
				pin_prev_q[g] <= 1'b0;
			end else if (STANDBY) begin
				pin_q[g] <= 1'b0;
				oe_q[g]  <= 1'b0;
				eq_q[g]  <= 1'b0;
				pin_prev_q[g] <= pin_in[g];
			end else begin
				eq_q[g]       <= eq;
				pin_prev_q[g] <= pin_in[g];
				if (io_wr) begin
					oe_q[g]  <= ~fnew[FS_CAPT] & (fnew[1:0] != OC_OFF); // [RQ2]
					pin_q[g] <= fnew[FS_INIT];      // [RQ3] [RQ4]
				end else if (cmp & oe_q[g]) begin
					case (fsel[1:0])
						OC_DRV0:   pin_q[g] <= 1'b0; // [RQ3] [RQ4]
						OC_DRV1:   pin_q[g] <= 1'b1;
						OC_TOGGLE: pin_q[g] <= ~pin_q[g];
						default:   pin_q[g] <= pin_q[g];
					endcase
				end
			end
		end
	end

	assign CH2_PIN_A_OUT = pin_q[0];
	assign CH2_PIN_B_OUT = pin_q[1];
	assign CH2_PIN_A_OE  = oe_q[0];
	assign CH2_PIN_B_OE  = oe_q[1];

	// ==========================================================
	// wrap detection; counter values come from the counter block
	// limitation: a counter load from ffff straight to 0000 also reads as a wrap
	logic [2:0] ovf_ev;
	logic [2:0] udf_ev;
	always_comb begin
		for (int c = 0; c < 3; c++) begin
			ovf_ev[c] = (&cnt_prev_q[c]) & (cnt[c] == '0);        // [RQ17]
			udf_ev[c] = (c != 0) & (cnt_prev_q[c] == '0) & (&cnt[c]); // [RQ17]
		end
	end

	// event vectors per channel in status bit layout
	always_comb begin
		for (int c = 0; c < 3; c++)
			ev[c] = 8'h00;
		ev[0][3:0] = CH0_MATCH;
		ev[1][1:0] = CH1_MATCH;
		ev[2][1:0] = match2;
		for (int c = 0; c < 3; c++) begin
			ev[c][BIT_OVF] = ovf_ev[c];
			ev[c][BIT_UDF] = udf_ev[c];
		end
	end

	// ==========================================================
	// status flags: clear needs a prior read as one, set wins
	localparam logic [7:0] ST_MASK [3] = '{STAT_MASK0, STAT_MASK12, STAT_MASK12};
	logic [7:0] clr [3];
	always_comb begin
		for (int c = 0; c < 3; c++) begin
			clr[c]    = (wr_done & hit_stat[c]) ? (arm_q[c] & ~wb) : 8'h00; // [RQ19]
			stat_d[c] = ((stat_q[c] & ~clr[c]) | ev[c]) & ST_MASK[c];      // [RQ19]
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int c = 0; c < 3; c++) begin
				stat_q[c]     <= 8'h00;
				arm_q[c]      <= 8'h00;
				cnt_prev_q[c] <= '0;
			end
		end else begin
			for (int c = 0; c < 3; c++) begin
				cnt_prev_q[c] <= cnt[c];
				if (STANDBY) begin
					stat_q[c] <= 8'h00;
					arm_q[c]  <= 8'h00;
				end else begin
					stat_q[c] <= stat_d[c];
					// arm on a read that saw the flag set
					arm_q[c]  <= ((rd_done & hit_stat[c]) ? (arm_q[c] | stat_q[c])
						: arm_q[c]) & stat_d[c];
				end
			end
		end
	end

	// ==========================================================
	// requests: registered flag AND enable, held while both stand; conversion start is the match A event AND enable
	logic [2:0] ovf_q;
	logic [2:0] udf_q;
	logic [2:0] ma_q;
	logic [2:0] mb_q;
	logic       mc_q;
	logic       md_q;
	logic [2:0] adc_q;
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ovf_q <= 3'h0;
			udf_q <= 3'h0;
			ma_q  <= 3'h0;
			mb_q  <= 3'h0;
			mc_q  <= 1'b0;
			md_q  <= 1'b0;
			adc_q <= 3'h0;
		end else begin
			for (int c = 0; c < 3; c++) begin
				ovf_q[c] <= stat_q[c][BIT_OVF] & ier_q[c][BIT_OVF]; // [RQ11] [RQ20]
				udf_q[c] <= stat_q[c][BIT_UDF] & ier_q[c][BIT_UDF]; // [RQ9] [RQ20]
				ma_q[c]  <= stat_q[c][BIT_MA] & ier_q[c][BIT_MA];   // [RQ16] [RQ20]
				mb_q[c]  <= stat_q[c][BIT_MB] & ier_q[c][BIT_MB];   // [RQ15] [RQ20]
				adc_q[c] <= ev[c][BIT_MA] & ier_q[c][BIT_ADC] & ~STANDBY; // [RQ7]
			end
			mc_q <= stat_q[0][BIT_MC] & ier_q[0][BIT_MC];           // [RQ13] [RQ20]
			md_q <= stat_q[0][BIT_MD] & ier_q[0][BIT_MD];           // [RQ12] [RQ20]
		end
	end
	assign OVERFLOW_IRQ  = ovf_q;
	assign UNDERFLOW_IRQ = udf_q;
	assign MATCH_A_IRQ   = ma_q;
	assign MATCH_B_IRQ   = mb_q;
	assign MATCH_C_IRQ   = mc_q;
	assign MATCH_D_IRQ   = md_q;
	assign ADC_START_REQ = adc_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);

	sequence s_oc_match_a;
		!ioctl_q[FS_CAPT] && ioctl_q[1:0] == OC_TOGGLE && oe_q[0]
			&& g_slice[0].cmp && !(wr_done && hit_io) && !STANDBY;
	endsequence

	sequence s_rise_capt_a;
		ioctl_q[3:0] == 4'h8 && CH2_PIN_A_IN && !pin_prev_q[0] && !STANDBY;
	endsequence

	ier_standby_a: assert property (STANDBY |=> ier_q[1] == IER_RST) // [RQ6]
		else $error("enable not reset by standby");
	ier_fixed_a: assert property (ier_q[2][BIT_ONE] && !ier_q[2][3] && !ier_q[2][2]) // [RQ14]
		else $error("fixed enable bits wrong");
	ier_ch0_a: assert property (wr_done && hit_ier[0] |=> !ier_q[0][BIT_UDF]) // [RQ10]
		else $error("ch0 bit 5 not zero");
	toggle_pin_a: assert property (s_oc_match_a |=> CH2_PIN_A_OUT != $past(CH2_PIN_A_OUT)) // [RQ3]
		else $error("compare toggle missed");
	capt_rise_a: assert property (s_rise_capt_a |=> gr_q[0] == $past(CH2_COUNT)
		&& stat_q[2][BIT_MA]) // [RQ5]
		else $error("rising capture missed");
	oe_off_a: assert property (wr_done && hit_io && wb[3:0] == 4'h4 |=> !CH2_PIN_A_OE) // [RQ2]
		else $error("pin driven for disabled code");
	ovf_flag_a: assert property (ovf_ev[1] && !STANDBY |=> stat_q[1][BIT_OVF]) // [RQ17]
		else $error("overflow flag not set");
	irq_tie_a: assert property (stat_q[1][BIT_UDF] && ier_q[1][BIT_UDF]
		|=> UNDERFLOW_IRQ[1] ##1 (UNDERFLOW_IRQ[1] == $past(stat_q[1][BIT_UDF]
		&& ier_q[1][BIT_UDF]))) // [RQ20]
		else $error("underflow request not tied to flag");
	clr_arm_a: assert property (stat_q[0][BIT_OVF] && !arm_q[0][BIT_OVF] && !ovf_ev[0]
		&& !STANDBY |=> stat_q[0][BIT_OVF]) // [RQ19]
		else $error("flag cleared without read");
	adc_req_a: assert property (ev[2][BIT_MA] && !ier_q[2][BIT_ADC] |=> !ADC_START_REQ[2]) // [RQ7]
		else $error("conversion start while disabled");

	// a cleared enable keeps its request low even with the flag set
	ovf_gate_a: assert property (!ier_q[0][BIT_OVF] |=> !OVERFLOW_IRQ[0]) // [RQ11]
		else $error("overflow request while disabled");
	ma_gate_a: assert property (!ier_q[1][BIT_MA] |=> !MATCH_A_IRQ[1]) // [RQ16]
		else $error("match a request while disabled");
endmodule : tioc_top
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the timer i/o control and interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module tb
	import tioc_pkg::*;
;
	// ==========================================================
	// stimulus and observed signals
	logic        ref_clk = 0, rst_b = 0, standby = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic        pready, pslverr, se, pa = 0, pa_o, pa_oe, pb_o, pb_oe, mc, md;
	logic        up = 0, dn = 0, ld = 0;
	logic [15:0] lv = 16'h0000, c2 = 16'h0000;
	wire logic [15:0] c1;
	logic [3:0]  m0 = 4'h0;
	logic [2:0]  ovf, udf, ma, mb, adc;
	int          hits, num_errors = 0, cmp_count = 0;

	always #20 ref_clk = ~ref_clk;

	tioc_top dut (.REF_CLK(ref_clk), .RST_B(rst_b), .STANDBY(standby), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .CH0_COUNT(c1), .CH1_COUNT(c1),
		.CH2_COUNT(c2), .CH0_MATCH(m0), .CH1_MATCH(m0[1:0]), .CH2_PIN_A_IN(pa),
		.CH2_PIN_A_OUT(pa_o), .CH2_PIN_A_OE(pa_oe), .CH2_PIN_B_IN(pa), .CH2_PIN_B_OUT(pb_o),
		.CH2_PIN_B_OE(pb_oe), .OVERFLOW_IRQ(ovf), .UNDERFLOW_IRQ(udf), .MATCH_A_IRQ(ma),
		.MATCH_B_IRQ(mb), .MATCH_C_IRQ(mc), .MATCH_D_IRQ(md), .ADC_START_REQ(adc));

	tioc_far_model far (.clk(ref_clk), .rst_b(rst_b), .up(up), .down(dn), .load(ld),
		.load_val(lv), .count_q(c1), .adc_req(adc[2]), .adc_hits(hits));

	// ==========================================================
	// shared tasks
	task automatic conclude;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	// apb transfer; entered just after a rising edge, waits a bounded time for ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			conclude();
		end
		// idle edge, so a following setup never rewrites psel in this step
		@(posedge ref_clk);
	endtask : apb

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask : rdchk

	// ==========================================================
	// scenarios
	task automatic s_reset_map;
		rdchk(OFS_IER0, 32'h0000_0040);
		rdchk(OFS_IER2, 32'h0000_0040);
		rdchk(OFS_IOCTL2, 32'h0000_0000);
		apb(1'b0, 8'h24, 32'h0000_0000);
		chk({rd[30:0], se}, 32'h0000_0001); // unmapped place refuses
		apb(1'b1, OFS_IER0, 32'h0000_00FF);
		rdchk(OFS_IER0, 32'h0000_00DF);
		apb(1'b1, OFS_IER1, 32'h0000_00BF);
		rdchk(OFS_IER1, 32'h0000_00F3);
		standby <= 1'b1;
		cyc(2);
		standby <= 1'b0;
		rdchk(OFS_IER1, 32'h0000_0040);
	endtask : s_reset_map

	// every compare code on both fields, then a match on field a
	task automatic s_compare;
		logic [3:0] f;
		logic       oe, e;
		apb(1'b1, OFS_IER2, 32'h0000_00C0);
		apb(1'b1, OFS_GRA2, 32'h0000_0100);
		for (int i = 0; i < 8; i++) begin
			f = 4'(i);
			oe = (f[1:0] != 2'h0);
			apb(1'b1, OFS_IOCTL2, {24'h0000_00, f, f});
			cyc(2);
			chk(32'({pb_oe, pb_o, pa_oe, pa_o}), 32'({oe, f[2], oe, f[2]}));
			if (oe) begin
				c2 <= 16'h0100;
				cyc(2);
				c2 <= 16'h0000;
				cyc(3);
				e = (f[1:0] == 2'h3) ? !f[2] : f[1];
				chk(32'(pa_o), 32'(e));
			end
		end
		chk(32'(hits), 32'd6);
		chk(32'(ma[2]), 32'h0000_0000);
	endtask : s_compare

	// rise, fall and both-edge capture on both fields, conversion start disabled
	task automatic s_capture;
		apb(1'b1, OFS_IER2, 32'h0000_0040);
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, OFS_IOCTL2, 32'h0000_0088 + 32'(k * 17));
			c2 <= 16'h1234 + 16'(k);
			cyc(3);
			pa <= 1'b1;
			cyc(3);
			rdchk(OFS_GRA2, (k == 1) ? 32'h0000_1234 : 32'h0000_1234 + 32'(k));
			c2 <= 16'h5678;
			cyc(1);
			pa <= 1'b0;
			cyc(3);
			rdchk(OFS_GRA2, (k == 0) ? 32'h0000_1234 : 32'h0000_5678);
			rdchk(OFS_GRB2, (k == 0) ? 32'h0000_1234 : 32'h0000_5678);
		end
		chk(32'(hits), 32'd6);
	endtask : s_capture

	// ch0 match events raise their requests one by one and stay up
	task automatic s_ch0_match;
		apb(1'b1, OFS_IER0, 32'h0000_000F);
		for (int i = 0; i < 4; i++) begin
			m0 <= 4'(1 << i);
			cyc(1);
			m0 <= 4'h0;
			cyc(3);
			chk(32'({md, mc, mb[0], ma[0]}), 32'((2 << i) - 1));
		end
		chk(32'({mb[1], ma[1]}), 32'h0000_0000);
	endtask : s_ch0_match

	task automatic s_wraps;
		apb(1'b1, OFS_IER1, 32'h0000_0070);
		ld <= 1'b1;
		lv <= 16'hFFFE;
		cyc(1);
		ld <= 1'b0;
		up <= 1'b1;
		cyc(3);
		up <= 1'b0;
		cyc(3);
		chk(32'(ovf[1]), 32'h0000_0001);
		rdchk(OFS_STAT1, 32'h0000_00D3);
		apb(1'b1, OFS_STAT1, 32'h0000_00FF);
		cyc(2);
		chk(32'(ovf[1]), 32'h0000_0001);
		apb(1'b1, OFS_STAT1, 32'h0000_00EF);
		cyc(2);
		chk(32'(ovf[1]), 32'h0000_0000);
		dn <= 1'b1;
		cyc(3);
		dn <= 1'b0;
		cyc(3);
		chk(32'(udf[1]), 32'h0000_0001);
		apb(1'b1, OFS_IER1, 32'h0000_0040);
		cyc(2);
		chk(32'(udf[1]), 32'h0000_0000);
		chk(32'(ovf[0]), 32'h0000_0000);
		rdchk(OFS_STAT0, 32'h0000_00DF);
	endtask : s_wraps

	// ==========================================================
	// main sequence
	initial begin
		cyc(8);
		rst_b <= 1'b1;
		cyc(1);
		s_reset_map();
		s_compare();
		s_capture();
		s_ch0_match();
		s_wraps();
		conclude();
	end
endmodule : tb
`default_nettype wire

// ### tb/tioc_far_model.sv
// far-side model: a channel counter source and the converter's start tally
`timescale 1ns/1ps
`default_nettype none
module tioc_far_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// counter steering from the bench
	input  wire logic        up,
	input  wire logic        down,
	input  wire logic        load,
	input  wire logic [15:0] load_val,
	// counter value and converter side
	output logic      [15:0] count_q,
	input  wire logic        adc_req,
	output var int           adc_hits
);
	// ==========================================================
	// counter wraps both ways, so the block sees real over/underflows
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) count_q <= 16'h0000;
		else if (load) count_q <= load_val; // a jump, never a wrap
		else if (up) count_q <= count_q + 16'h0001;
		else if (down) count_q <= count_q - 16'h0001;
	end
	// converter counts each start pulse it is handed
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) adc_hits <= 0;
		else if (adc_req) adc_hits <= adc_hits + 1;
	end
endmodule : tioc_far_model
`default_nettype wire
